/* design/delc_bank_if.sv */
// Interface between the controller and one 32-channel event bank.
`timescale 1ns/1ps
`default_nettype none
interface delc_bank_if #(
   parameter int W = 32
);
   logic [W-1:0] set;
   logic [W-1:0] sw_clear;
   logic [W-1:0] hw_ack;
   logic [W-1:0] enable;
   logic [W-1:0] events;
   logic [W-1:0] request;
   logic [W-1:0] miss;
   logic         disabled_hit;

   modport bank (
      input  set,
      input  sw_clear,
      input  hw_ack,
      input  enable,
      output events,
      output request,
      output miss,
      output disabled_hit
   );

   modport ctrl (
      output set,
      output sw_clear,
      output hw_ack,
      output enable,
      input  events,
      input  request,
      input  miss,
      input  disabled_hit
   );
endinterface
`default_nettype wire

/* design/delc_event_bank.sv */
// One bank of event latches with hardware and software clear.
`timescale 1ns/1ps
`default_nettype none
module delc_event_bank
   import delc_pkg::*;
#(
   parameter int W = 32
) (
   input  wire logic   sys_clk_i,
   input  wire logic   rst_i,
   delc_bank_if.bank   bank
);

   typedef struct packed {
      logic [W-1:0] events;
      logic [W-1:0] request;
      logic [W-1:0] miss;
   } delc_bank_state_type;

   delc_bank_state_type state;
   delc_bank_state_type next_state;
   logic [W-1:0]        hw_clear;

   // ****************************************************************
   // Latch, clear and miss detection
   // ****************************************************************
   always_comb
   begin
      next_state = state;
      // Service only clears a bit that is actually latched.
      hw_clear = bank.hw_ack & state.events; // RULE3 RULE15
      // Set wins over either clear; a bit holds until cleared.
      next_state.events = bank.set
         | (state.events & ~(hw_clear | bank.sw_clear)); // RULE1 RULE5 RULE6 RULE11
      next_state.miss = bank.set & state.events & bank.enable; // RULE4 RULE7
      next_state.request = next_state.events & bank.enable; // RULE2 RULE7
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         state.events  <= W'(EVENT_RESET); // RULE9
         state.request <= '0;
         state.miss    <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign bank.events       = state.events;
   assign bank.request      = state.request;
   assign bank.miss         = state.miss;
   assign bank.disabled_hit = |(bank.set & ~bank.enable);

endmodule
`default_nettype wire

/* design/delc_pkg.sv */
// Package holding the constants of the channel event latch and clear block.
package delc_pkg;

   // ****************************************************************
   // Sizes
   // ****************************************************************
   localparam int CHANNELS      = 64;
   localparam int HALF          = 32;
   localparam int ADDR_W        = 12;
   localparam int DATA_W        = 32;
   localparam int WIN_BITS      = 5;
   localparam int REGIONS_DFLT  = 4;

   // ****************************************************************
   // Register offsets inside one window
   // ****************************************************************
   localparam logic [WIN_BITS-1:0] OFF_EVENT_LOW  = 5'h00;
   localparam logic [WIN_BITS-1:0] OFF_EVENT_HIGH = 5'h04;
   localparam logic [WIN_BITS-1:0] OFF_CLEAR_LOW  = 5'h08;
   localparam logic [WIN_BITS-1:0] OFF_CLEAR_HIGH = 5'h0C;
   localparam logic [WIN_BITS-1:0] OFF_STATUS     = 5'h10;
   localparam logic [WIN_BITS-1:0] OFF_MASK       = 5'h14;

   // ****************************************************************
   // Address windows
   // ****************************************************************
   localparam logic [ADDR_W-1:0] SHADOW_BASE   = 12'h200;
   localparam int                SHADOW_STRIDE = 32;

   // ****************************************************************
   // Status layout and reset values
   // ****************************************************************
   localparam int                STAT_W            = 2;
   localparam int                STAT_MISSED_BIT   = 0;
   localparam int                STAT_DISABLED_BIT = 1;
   localparam logic [HALF-1:0]   EVENT_RESET       = 32'h0000_0000;
   localparam logic [STAT_W-1:0] STATUS_RESET      = 2'h0;
   localparam logic [STAT_W-1:0] MASK_RESET        = 2'h0;
   localparam logic [DATA_W-1:0] RDATA_IDLE        = 32'h0000_0000;

endpackage

/* design/delc_top.sv */
// Channel event latch and clear block with register port and interrupt.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// (RULE1) Every external event latches its channel bit, enabled or not.
// (RULE2) A latched event is requested onward only while its enable is one.
// (RULE3) A serviced event bit clears itself in hardware.
// (RULE4) A repeat event on a set, enabled bit raises the missed flag.
// (RULE5) Writing one to a clear bit clears that event; zero does nothing.
// (RULE6) Set beats hardware or software clear in the same cycle.
// (RULE7) Concurrent set and clear: miss if already set and enabled, else stays set.
// (RULE8) Channels 0-31 sit in the low word, 32-63 in the high word.
// (RULE9) Event registers are read-only and reset to zero.
// (RULE10) Clear registers are write-only strobes reading as zero.
// (RULE11) A set bit holds until serviced or cleared by software.
// (RULE12) Software discards events of disabled channels via clear writes.
// (RULE13) Enabled pending events compete with others for submission.
// (RULE14) Global and shadow windows; shadow gated by region access enables.
// (RULE15) Service acknowledge is a one-cycle pulse; clear on next edge.
module delc_top
   import delc_pkg::*;
#(
   parameter int REGIONS = REGIONS_DFLT
) (
   input  wire logic                             sys_clk_i,
   input  wire logic                             rst_i,
   input  wire logic [ADDR_W-1:0]                reg_addr_i,
   input  wire logic [DATA_W-1:0]                reg_wdata_i,
   input  wire logic                             reg_wr_i,
   input  wire logic                             reg_rd_i,
   output logic      [DATA_W-1:0]                reg_rdata_o,
   input  wire logic [CHANNELS-1:0]              ext_event_i,
   input  wire logic [CHANNELS-1:0]              chan_enable_i,
   input  wire logic [CHANNELS-1:0]              service_ack_i,
   input  wire logic [REGIONS-1:0][CHANNELS-1:0] region_access_enable_i,
   output logic      [CHANNELS-1:0]              event_request_o,
   output logic      [CHANNELS-1:0]              missed_event_set_o,
   output logic                                  irq_o
);

   localparam int REGION_BITS = $clog2(REGIONS);
   localparam int IDX_W       = ADDR_W - WIN_BITS;
   localparam logic [IDX_W-1:0] REGION_LIMIT = IDX_W'(REGIONS);

   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   generate
      if (REGIONS < 2 ||
          int'(SHADOW_BASE) + REGIONS * SHADOW_STRIDE > (1 << ADDR_W))
      begin : g_bad_regions
         $error("REGIONS does not fit the shadow address space");
      end
   endgenerate

   typedef struct packed {
      logic [DATA_W-1:0] rdata;
      logic [STAT_W-1:0] status;
      logic [STAT_W-1:0] mask;
      logic              irq;
   } delc_state_type;

   delc_state_type           state;
   delc_state_type           next_state;
   logic [WIN_BITS-1:0]      win_off;
   logic [ADDR_W-1:0]        shadow_off;
   logic [IDX_W-1:0]         shadow_idx;
   logic [REGION_BITS-1:0]   region;
   logic                     in_global;
   logic                     in_shadow;
   logic [CHANNELS-1:0]      access;
   logic [CHANNELS-1:0]      sw_clear;
   logic [CHANNELS-1:0]      events_all;
   logic [STAT_W-1:0]        stat_w1c;
   logic [STAT_W-1:0]        stat_set;

   delc_bank_if #(.W(HALF)) lo_if ();
   delc_bank_if #(.W(HALF)) hi_if ();

   // ****************************************************************
   // Event banks
   // ****************************************************************
   assign lo_if.set    = ext_event_i[HALF-1:0]; // RULE8
   assign hi_if.set    = ext_event_i[CHANNELS-1:HALF]; // RULE8
   assign lo_if.hw_ack = service_ack_i[HALF-1:0];
   assign hi_if.hw_ack = service_ack_i[CHANNELS-1:HALF];
   assign lo_if.enable = chan_enable_i[HALF-1:0];
   assign hi_if.enable = chan_enable_i[CHANNELS-1:HALF];
   assign lo_if.sw_clear = sw_clear[HALF-1:0];
   assign hi_if.sw_clear = sw_clear[CHANNELS-1:HALF];
   assign events_all = {hi_if.events, lo_if.events};

   delc_event_bank #(
      .W (HALF)
   ) u_bank_lo (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .bank      (lo_if.bank)
   );

   delc_event_bank #(
      .W (HALF)
   ) u_bank_hi (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .bank      (hi_if.bank)
   );

   // ****************************************************************
   // Address decode, register access and interrupt
   // ****************************************************************
   always_comb
   begin
      next_state = state;
      win_off    = reg_addr_i[WIN_BITS-1:0];
      shadow_off = reg_addr_i - SHADOW_BASE;
      shadow_idx = shadow_off[ADDR_W-1:WIN_BITS];
      region     = shadow_idx[REGION_BITS-1:0];
      in_global  = (reg_addr_i[ADDR_W-1:WIN_BITS] == '0);
      in_shadow  = (reg_addr_i >= SHADOW_BASE) && (shadow_idx < REGION_LIMIT);
      // Shadow windows see only the channels granted to their region.
      if (in_global)
      begin
         access = '1; // RULE14
      end
      else if (in_shadow)
      begin
         access = region_access_enable_i[region]; // RULE14
      end
      else
      begin
         access = '0;
      end
      sw_clear = '0;
      stat_w1c = '0;
      if (reg_wr_i && (in_global || in_shadow))
      begin
         case (win_off)
            OFF_CLEAR_LOW:
            begin
               sw_clear[HALF-1:0] = reg_wdata_i & access[HALF-1:0]; // RULE5 RULE12
            end
            OFF_CLEAR_HIGH:
            begin
               sw_clear[CHANNELS-1:HALF] =
                  reg_wdata_i & access[CHANNELS-1:HALF]; // RULE5 RULE12
            end
            OFF_STATUS:
            begin
               if (in_global)
               begin
                  stat_w1c = reg_wdata_i[STAT_W-1:0];
               end
            end
            OFF_MASK:
            begin
               if (in_global)
               begin
                  next_state.mask = reg_wdata_i[STAT_W-1:0];
               end
            end
            default:
            begin
               // Writes to the event words and to unmapped offsets are
               // ignored, which keeps the event words read-only.
               sw_clear = '0; // RULE9
            end
         endcase
      end
      next_state.rdata = RDATA_IDLE;
      if (reg_rd_i && (in_global || in_shadow))
      begin
         case (win_off)
            OFF_EVENT_LOW:
            begin
               next_state.rdata = lo_if.events & access[HALF-1:0]; // RULE8
            end
            OFF_EVENT_HIGH:
            begin
               next_state.rdata =
                  hi_if.events & access[CHANNELS-1:HALF]; // RULE8
            end
            OFF_STATUS:
            begin
               if (in_global)
               begin
                  next_state.rdata = DATA_W'(state.status);
               end
            end
            OFF_MASK:
            begin
               if (in_global)
               begin
                  next_state.rdata = DATA_W'(state.mask);
               end
            end
            default:
            begin
               // Clear words hold no state and read as zero.
               next_state.rdata = RDATA_IDLE; // RULE10
            end
         endcase
      end
      stat_set = '0;
      stat_set[STAT_MISSED_BIT]   = (|lo_if.miss) | (|hi_if.miss);
      stat_set[STAT_DISABLED_BIT] = lo_if.disabled_hit | hi_if.disabled_hit;
      // A new event wins over a clear written in the same cycle.
      next_state.status = (state.status & ~stat_w1c) | stat_set;
      next_state.irq    = |(next_state.status & next_state.mask);
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         state.rdata  <= RDATA_IDLE;
         state.status <= STATUS_RESET;
         state.mask   <= MASK_RESET;
         state.irq    <= 1'b0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign reg_rdata_o        = state.rdata;
   // Enabled pending events go to prioritization beside the other sources.
   assign event_request_o    = {hi_if.request, lo_if.request}; // RULE13
   assign missed_event_set_o = {hi_if.miss, lo_if.miss};
   assign irq_o              = state.irq;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   a_event_latched: assert property ( // RULE1 RULE6
      ##1 ((events_all & $past(ext_event_i)) == $past(ext_event_i)))
      else $error("incoming event not latched");

   a_request_gated: assert property ( // RULE2 RULE13
      ##1 (event_request_o == (events_all & $past(chan_enable_i))))
      else $error("request does not follow event and enable");

   a_service_clear: assert property ( // RULE3 RULE15
      ##1 ((events_all
         & $past(service_ack_i & events_all & ~ext_event_i)) == '0))
      else $error("serviced event not cleared on next edge");

   a_missed_flag: assert property ( // RULE4 RULE7
      ##1 (missed_event_set_o
         == $past(ext_event_i & events_all & chan_enable_i)))
      else $error("missed event flag wrong");

   a_soft_clear: assert property ( // RULE5
      (reg_wr_i && in_global && win_off == OFF_CLEAR_LOW)
      |=> ((lo_if.events & $past(reg_wdata_i)
         & ~$past(ext_event_i[HALF-1:0])) == '0))
      else $error("software clear did not clear event");

   a_bits_hold: assert property ( // RULE11 RULE5 RULE9
      ##1 (((events_all ^ $past(events_all))
         & $past(~(ext_event_i | service_ack_i | sw_clear))) == '0))
      else $error("event bit changed without cause");

   a_reset_zero: assert property ( // RULE9
      $past(rst_i) |-> (events_all == '0))
      else $error("event bits not zero after reset");

   a_clear_reads_zero: assert property ( // RULE10
      (reg_rd_i && (win_off == OFF_CLEAR_LOW || win_off == OFF_CLEAR_HIGH))
      |=> (reg_rdata_o == RDATA_IDLE))
      else $error("clear register read not zero");

   a_high_word_map: assert property ( // RULE8
      (reg_rd_i && in_global && win_off == OFF_EVENT_HIGH)
      |=> (reg_rdata_o == $past(hi_if.events)))
      else $error("high event word mismatch");

   a_shadow_gate: assert property ( // RULE14
      (reg_rd_i && in_shadow && win_off == OFF_EVENT_LOW)
      |=> (reg_rdata_o == $past(lo_if.events & access[HALF-1:0])))
      else $error("shadow read not gated by region enables");

   a_irq_level: assert property (
      irq_o == |(state.status & state.mask))
      else $error("interrupt level wrong");

   a_low_word_map: assert property ( // RULE8
      (reg_rd_i && in_global && win_off == OFF_EVENT_LOW)
      |=> (reg_rdata_o == $past(lo_if.events)))
      else $error("low event word mismatch");

   a_soft_clear_high: assert property ( // RULE5
      (reg_wr_i && in_global && win_off == OFF_CLEAR_HIGH)
      |=> ((hi_if.events & $past(reg_wdata_i)
         & ~$past(ext_event_i[CHANNELS-1:HALF])) == '0))
      else $error("software clear did not clear high event");

   a_event_readonly: assert property ( // RULE9
      (reg_wr_i && (win_off == OFF_EVENT_LOW || win_off == OFF_EVENT_HIGH))
      |-> (sw_clear == '0))
      else $error("write to event word cleared events");

   a_outside_refused: assert property ( // RULE14
      (reg_wr_i && int'(reg_addr_i) >= int'(SHADOW_BASE)
         + REGIONS * SHADOW_STRIDE)
      |-> (sw_clear == '0))
      else $error("write outside all windows cleared events");

   a_shadow_clear_gate: assert property ( // RULE14
      (reg_wr_i && in_shadow && win_off == OFF_CLEAR_LOW)
      |-> ((sw_clear[HALF-1:0]
         & ~region_access_enable_i[region][HALF-1:0]) == '0))
      else $error("shadow clear hit a channel without access");

   a_request_latched: assert property ( // RULE2
      (event_request_o & ~events_all) == '0)
      else $error("request without latched event");

   a_miss_needs_bit: assert property ( // RULE4 RULE7
      (missed_event_set_o & ~events_all) == '0)
      else $error("missed flag without latched event");

   a_rdata_idle: assert property (
      !reg_rd_i |=> (reg_rdata_o == RDATA_IDLE))
      else $error("read data outside the answer cycle");

   a_miss_status: assert property (
      (|missed_event_set_o) |=> state.status[STAT_MISSED_BIT])
      else $error("missed event not recorded in status");

   a_disabled_status: assert property ( // RULE1
      (|(ext_event_i & ~chan_enable_i)) |=> state.status[STAT_DISABLED_BIT])
      else $error("disabled event not recorded in status");

   c_missed_event: cover property (|missed_event_set_o);
   c_set_and_clear: cover property (|(ext_event_i & sw_clear & events_all));
   c_service: cover property (|(service_ack_i & events_all));
   c_shadow_clear: cover property (reg_wr_i && in_shadow && |sw_clear);
   c_irq: cover property (irq_o);

endmodule
`default_nettype wire

/* verif/delc_partner.sv */
// Model of the prioritization logic that acknowledges offered events.
`timescale 1ns/1ps
`default_nettype none
module delc_partner
   import delc_pkg::*;
(
   input  wire logic                sys_clk_i,
   input  wire logic                rst_i,
   input  wire logic                prompt_i,
   input  wire logic [CHANNELS-1:0] request_i,
   output logic      [CHANNELS-1:0] service_ack_o
);
   // A stalled partner leaves requests pending; acks never last two cycles.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         service_ack_o <= '0;
      else if (prompt_i)
         service_ack_o <= request_i & ~service_ack_o;
      else
         service_ack_o <= '0;
   end
endmodule
`default_nettype wire

/* verif/test_dma_event_latch_clear.sv */
// Self-checking bench of the channel event latch and clear block.
`timescale 1ns/1ps
`default_nettype none
module test_dma_event_latch_clear
   import delc_pkg::*;
;
   // ****************************************************************
   // Signals
   // ****************************************************************
   localparam int NREG  = 4;
   localparam int LIMIT = 6000;
   localparam logic [7:0][ADDR_W-1:0] TBL = {12'h000, 12'h004, 12'h008,
      12'h00C, 12'h01C, 12'h300, 12'h22C, 12'h260};
   logic                          clk    = 1'b0;
   logic                          rst    = 1'b1;
   logic [ADDR_W-1:0]             addr   = '0;
   logic [DATA_W-1:0]             wdata  = '0;
   logic                          wr     = 1'b0;
   logic                          rd     = 1'b0;
   logic                          prompt = 1'b0;
   logic [CHANNELS-1:0]           ext    = '0;
   logic [CHANNELS-1:0]           en     = '0;
   logic [NREG-1:0][CHANNELS-1:0] grant  = '0;
   logic [DATA_W-1:0]             rdata, rd_exp;
   logic [CHANNELS-1:0]           req, miss, ack, ev_m, en_m, miss_m;
   logic                          irq, st_m, st1_m;
   logic [1:0]                    mask_m;
   logic [31:0]                   seed   = 32'h5;
   logic [31:0]                   a, b, c;
   int                            miscompares = 0, n_checks = 0, cycles = 0;

   always #2 clk = ~clk;

   delc_top #(.REGIONS(NREG)) delc_top_inst (
      .sys_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .ext_event_i(ext),
      .chan_enable_i(en), .service_ack_i(ack), .region_access_enable_i(grant),
      .event_request_o(req), .missed_event_set_o(miss), .irq_o(irq));

   delc_partner delc_partner_inst (
      .sys_clk_i(clk), .rst_i(rst), .prompt_i(prompt), .request_i(req),
      .service_ack_o(ack));

   // ****************************************************************
   // Expectation functions
   // ****************************************************************
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return x[0] ? ((x >> 1) ^ 32'h8020_0003) : (x >> 1);
   endfunction

   // Channels that an address window may reach; zero outside all windows.
   function automatic logic [CHANNELS-1:0] win(input logic [ADDR_W-1:0] x,
      input logic [NREG-1:0][CHANNELS-1:0] g);
      if (x < 12'h020)
         return '1;
      if (x >= SHADOW_BASE && x < SHADOW_BASE + NREG * SHADOW_STRIDE)
         return g[(int'(x) - int'(SHADOW_BASE)) / SHADOW_STRIDE];
      return '0;
   endfunction

   function automatic logic [DATA_W-1:0] rd_fn(input logic [ADDR_W-1:0] x,
      input logic [CHANNELS-1:0] ev, input logic [NREG-1:0][CHANNELS-1:0] g);
      logic [CHANNELS-1:0] m;
      m = ev & win(x, g);
      if (x[WIN_BITS-1:0] == OFF_EVENT_LOW)
         return m[HALF-1:0];
      if (x[WIN_BITS-1:0] == OFF_EVENT_HIGH)
         return m[CHANNELS-1:HALF];
      return '0;
   endfunction

   function automatic logic [CHANNELS-1:0] clr_fn(input logic [ADDR_W-1:0] x,
      input logic [DATA_W-1:0] d, input logic [NREG-1:0][CHANNELS-1:0] g);
      if (x[WIN_BITS-1:0] == OFF_CLEAR_LOW)
         return {32'h0, d} & win(x, g);
      if (x[WIN_BITS-1:0] == OFF_CLEAR_HIGH)
         return {d, 32'h0} & win(x, g);
      return '0;
   endfunction

   // ****************************************************************
   // Reference model and per-cycle comparison
   // ****************************************************************
   always @(posedge clk)
   begin
      if (rst)
      begin
         ev_m   <= '0;
         en_m   <= '0;
         miss_m <= '0;
         rd_exp <= '0;
         st_m   <= 1'b0;
         st1_m  <= 1'b0;
         mask_m <= 2'h0;
      end
      else
      begin
         ev_m   <= (ev_m & ~ack & ~(wr ? clr_fn(addr, wdata, grant) : '0))
                   | ext;
         miss_m <= ext & ev_m & en;
         en_m   <= en;
         if (rd && addr == 12'h010)
            rd_exp <= {30'h0, st1_m, st_m};
         else if (rd && addr == 12'h014)
            rd_exp <= {30'h0, mask_m};
         else
            rd_exp <= rd ? rd_fn(addr, ev_m, grant) : '0;
         st_m   <= (|miss_m) | (st_m & ~(wr && addr == 12'h010 && wdata[0]));
         st1_m  <= (|(ext & ~en))
                   | (st1_m & ~(wr && addr == 12'h010 && wdata[1]));
         if (wr && addr == 12'h014)
            mask_m <= wdata[1:0];
      end
   end

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp,
      input string what);
      n_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what,
            seen, exp);
      end
   endtask

   always @(negedge clk)
   begin
      if (!rst)
      begin
         chk(req, ev_m & en_m, "request");
         chk(miss, miss_m, "missed");
         chk(rdata, rd_exp, "read data");
         chk(irq, |({st1_m, st_m} & mask_m), "interrupt");
      end
   end

   // ****************************************************************
   // Stimulus
   // ****************************************************************
   task automatic drive(input logic [CHANNELS-1:0] e, input logic w,
      input logic r, input logic [ADDR_W-1:0] x, input logic [DATA_W-1:0] d);
      @(posedge clk);
      ext   <= e;
      wr    <= w;
      rd    <= r;
      addr  <= x;
      wdata <= d;
   endtask

   task automatic finish_test;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         miscompares++;
         finish_test();
      end
   end

   initial
   begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      drive('0, 1'b0, 1'b0, '0, '0);
      en <= '1;
      drive('0, 1'b1, 1'b0, 12'h014, 32'h1);
      drive(64'h0000_0100_0000_0000, 1'b0, 1'b0, '0, '0);
      // Channel 40 set and 41 clear, both hit by a clear and a new event.
      drive(64'h0000_0300_0000_0000, 1'b1, 1'b0, 12'h00C, 32'h300);
      drive('0, 1'b0, 1'b1, 12'h004, '0);
      drive('0, 1'b0, 1'b1, 12'h000, '0);
      for (int i = 0; i < 4000; i++)
      begin
         seed = lfsr(seed);
         a = seed;
         seed = lfsr(seed);
         b = seed;
         seed = lfsr(seed);
         c = seed;
         // Clears of all ones also discard events of disabled channels.
         drive({a & b & c, a & c & ~b}, a[2:0] == 3'h0, a[2:0] == 3'h1,
            TBL[b[2:0]], c[4] ? 32'hFFFF_FFFF : c);
         if (i % 64 == 0)
         begin
            en     <= {a, b};
            grant  <= {a, b, c, a, b, c, a, b};
            prompt <= a[5];
         end
      end
      drive('0, 1'b1, 1'b0, 12'h014, 32'h3);
      drive('0, 1'b0, 1'b1, 12'h010, '0);
      drive('0, 1'b0, 1'b1, 12'h014, '0);
      drive('0, 1'b1, 1'b0, 12'h010, 32'h3);
      drive('0, 1'b1, 1'b0, 12'h014, 32'h0);
      drive('0, 1'b0, 1'b0, '0, '0);
      // A second reset in mid-run must empty every event bit again.
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      drive('0, 1'b0, 1'b1, 12'h004, '0);
      drive('0, 1'b0, 1'b1, 12'h000, '0);
      drive('0, 1'b0, 1'b0, '0, '0);
      repeat (3) @(posedge clk);
      finish_test();
   end
endmodule
`default_nettype wire
